// File: core/ompc_pkg.sv
// package of constants and types for the operating-mode power controller
package ompc_pkg;
   // ==========================================
   // mode encoding (gray along green-halt-start and green-normal steps)
   typedef enum logic [2:0] {
      OMPC_GREEN  = 3'h0,
      OMPC_NORMAL = 3'h4,
      OMPC_SLEEP  = 3'h1,
      OMPC_IDLE   = 3'h2,
      OMPC_START  = 3'h3
   } ompc_state_t;

   // ==========================================
   // watchdog clock source select
   localparam logic [1:0] WDT_SRC_INSTR = 2'h0;
   localparam logic [1:0] WDT_SRC_32K   = 2'h1;
   localparam logic [1:0] WDT_SRC_OWN   = 2'h2;

   // ==========================================
   // timing
   localparam int          STARTUP_CYCLES = 1024;
   localparam logic [10:0] STARTUP_LAST   = 11'h3ff;
   localparam int          PA_WIDTH       = 8;
   localparam int          IRQ_WIDTH      = 8;
   // interrupt lines that need the 32768Hz crystal (timers, rtc, dialer)
   localparam logic [7:0]  IRQ_NEEDS_32K  = 8'h0f;
   // build-time port A wake mask default
   localparam logic [7:0]  PA_WAKE_MASK   = 8'hff;

   // ==========================================
   // reset values
   localparam logic RST_PDF = 1'b0;
   localparam logic RST_TO  = 1'b0;
endpackage : ompc_pkg

// File: core/ompc_ctrl.sv
// operating-mode and halt/wake controller
`timescale 1ns/1ps
module ompc_ctrl #(
   parameter logic [7:0] PA_WAKE = ompc_pkg::PA_WAKE_MASK
) (
   input  wire logic       ref_clk,
   input  wire logic       rst_b,
   input  wire logic       halt_exec,
   input  wire logic       mode_select_high,
   input  wire logic       mode_select_low,
   input  wire logic       upconvert_enable,
   input  wire logic       ext_reset_evt,
   input  wire logic       wdt_timeout_evt,
   input  wire logic [7:0] irq_req,
   input  wire logic [7:0] irq_enable,
   input  wire logic       stack_full,
   input  wire logic [7:0] port_a_pins,
   input  wire logic [1:0] wdt_src_sel,
   input  wire logic       wdt_enable,
   output logic            sys_clk_en,
   output logic            osc_32k_en,
   output logic            osc_fast_en,
   output logic            fast_clk_sel,
   output logic            cpu_run,
   output logic            irq_take,
   output logic            watchdog_run,
   output logic            watchdog_clear,
   output logic            power_down_flag,
   output logic            timeout_flag
);
   // ==========================================
   // port A synchroniser: three stages, change seen when 2nd and 3rd agree
   logic [7:0] pa_s1_q, pa_s2_q, pa_s3_q, pa_st_q;
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         pa_s1_q <= 8'hff;
         pa_s2_q <= 8'hff;
         pa_s3_q <= 8'hff;
      end else begin
         pa_s1_q <= port_a_pins;
         pa_s2_q <= pa_s1_q;
         pa_s3_q <= pa_s2_q;
      end
   end
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++) begin : g_pa
         always_ff @(posedge ref_clk or negedge rst_b) begin
            if (!rst_b)
               pa_st_q[gi] <= 1'b1;
            else if (pa_s2_q[gi] == pa_s3_q[gi])
               pa_st_q[gi] <= pa_s3_q[gi];
         end
      end
   endgenerate

   // ==========================================
   // state and decode
   ompc_pkg::ompc_state_t state_q, state_d;
   logic [10:0] sst_q;
   logic [7:0]  pa_ref_q;      // port A level captured at halt
   logic [7:0]  irq_pre_q;     // flags already set at halt
   logic        wake_irq_q;    // wake came from an acknowledged irq
   logic        irq_wait_q;
   logic        in_halt, is_idle, halt_go;
   logic [7:0]  irq_live, irq_wake_v, pa_wake_v;
   logic        any_reset, irq_wake, pa_wake, wake, irq_ack, sst_done;

   assign in_halt    = (state_q == ompc_pkg::OMPC_SLEEP) ||
                       (state_q == ompc_pkg::OMPC_IDLE);
   assign is_idle    = (state_q == ompc_pkg::OMPC_IDLE);
   // only taken from green: normal, start-up and halt refuse it
   assign halt_go    = halt_exec && !mode_select_high &&
                       !upconvert_enable &&
                       (state_q == ompc_pkg::OMPC_GREEN);
   // crystal-dependent lines are dead while idle
   assign irq_live   = is_idle ? (irq_req & ~ompc_pkg::IRQ_NEEDS_32K)
                               : irq_req;
   assign irq_wake_v = irq_live & ~irq_pre_q;
   assign irq_wake   = in_halt && (|irq_wake_v);
   assign pa_wake_v  = (pa_st_q ^ pa_ref_q) & PA_WAKE;
   assign pa_wake    = in_halt && (|pa_wake_v);
   assign any_reset  = ext_reset_evt || wdt_timeout_evt;
   assign wake       = in_halt && (irq_wake || pa_wake);
   // take interrupt only if enabled and stack has room
   assign irq_ack    = |(irq_wake_v & irq_enable) && !stack_full;
   assign sst_done   = (state_q == ompc_pkg::OMPC_START) &&
                       (sst_q == ompc_pkg::STARTUP_LAST);

   always_comb begin
      state_d = state_q;
      unique case (state_q)
         ompc_pkg::OMPC_GREEN: begin
            if (halt_go)
               state_d = mode_select_low ? ompc_pkg::OMPC_IDLE
                                         : ompc_pkg::OMPC_SLEEP;
            else if (mode_select_high && upconvert_enable)
               state_d = ompc_pkg::OMPC_NORMAL;
         end
         ompc_pkg::OMPC_NORMAL: begin
            if (!mode_select_high || !upconvert_enable)
               state_d = ompc_pkg::OMPC_GREEN;
         end
         ompc_pkg::OMPC_SLEEP, ompc_pkg::OMPC_IDLE: begin
            if (any_reset || wake)
               state_d = ompc_pkg::OMPC_START;
         end
         ompc_pkg::OMPC_START: begin
            if (sst_done)
               state_d = ompc_pkg::OMPC_GREEN;
         end
         default: state_d = ompc_pkg::OMPC_GREEN;
      endcase
   end

   // ==========================================
   // registers
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         state_q <= ompc_pkg::OMPC_START;
         sst_q   <= 11'h000;
      end else begin
         state_q <= state_d;
         sst_q   <= (state_q == ompc_pkg::OMPC_START && !sst_done)
                    ? sst_q + 11'h001 : 11'h000;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         pa_ref_q   <= 8'hff;
         irq_pre_q  <= 8'h00;
         wake_irq_q <= 1'b0;
         irq_wait_q <= 1'b0;
      end else begin
         if (halt_go) begin
            pa_ref_q  <= pa_st_q;
            irq_pre_q <= irq_req;
         end
         if (in_halt && any_reset)
            wake_irq_q <= 1'b0;
         else if (in_halt && wake)
            wake_irq_q <= irq_wake && irq_ack;
         // one extra cycle before the service routine
         irq_wait_q <= sst_done && wake_irq_q;
      end
   end

   // flags: halt sets pd, clears to; reset events record source
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         power_down_flag <= ompc_pkg::RST_PDF;
         timeout_flag    <= ompc_pkg::RST_TO;
      end else if (halt_go) begin
         power_down_flag <= 1'b1;
         timeout_flag    <= 1'b0;
      end else if (wdt_timeout_evt) begin
         timeout_flag    <= 1'b1;
      end else if (ext_reset_evt && in_halt) begin
         timeout_flag    <= 1'b0;
      end
   end

   // ==========================================
   // outputs, all registered; irq_take from irq_wait_q, the others from next state
   logic st_halt_d, st_idle_d, st_norm_d, st_run_d, wd_run_d;
   assign st_halt_d = (state_d == ompc_pkg::OMPC_SLEEP) ||
                      (state_d == ompc_pkg::OMPC_IDLE);
   assign st_idle_d = (state_d == ompc_pkg::OMPC_IDLE);
   assign st_norm_d = (state_d == ompc_pkg::OMPC_NORMAL);
   assign st_run_d  = (state_d == ompc_pkg::OMPC_GREEN) ||
                      (state_d == ompc_pkg::OMPC_NORMAL);
   assign wd_run_d  = wdt_enable &&
      !(st_halt_d && wdt_src_sel == ompc_pkg::WDT_SRC_INSTR) &&
      !(st_idle_d && wdt_src_sel == ompc_pkg::WDT_SRC_32K);

   // ram, registers and ports are untouched: only the clock gates drop
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         sys_clk_en     <= 1'b1;
         osc_32k_en     <= 1'b1;
         osc_fast_en    <= 1'b0;
         fast_clk_sel   <= 1'b0;
         cpu_run        <= 1'b0;
         irq_take       <= 1'b0;
         watchdog_run   <= 1'b0;
         watchdog_clear <= 1'b0;
      end else begin
         sys_clk_en     <= !st_halt_d;
         osc_32k_en     <= !st_idle_d;
         osc_fast_en    <= upconvert_enable && !st_halt_d;
         fast_clk_sel   <= st_norm_d;
         cpu_run        <= st_run_d;
         irq_take       <= irq_wait_q;
         watchdog_run   <= wd_run_d;
         watchdog_clear <= halt_go && wd_run_d;
      end
   end

   // ==========================================
   // assertions
   // one clock domain; nothing here means anything while in reset
   default clocking cb_core @(posedge ref_clk);
   endclocking
   default disable iff (!rst_b);

   a_halt_flags: assert property (
      halt_go |=> power_down_flag && !timeout_flag)
      else $error("halt did not set flags");
   a_halt_clock_off: assert property (
      halt_go |=> !sys_clk_en && !cpu_run)
      else $error("system clock not stopped at halt");
   a_idle_osc_off: assert property (
      halt_go && mode_select_low |=> !osc_32k_en)
      else $error("idle kept crystal running");
   a_sleep_osc_on: assert property (
      halt_go && !mode_select_low |=> osc_32k_en)
      else $error("sleep stopped crystal");
   a_reset_wakes: assert property (
      in_halt && any_reset |=> state_q == ompc_pkg::OMPC_START)
      else $error("reset did not wake");
   a_irq_wakes: assert property (
      irq_wake |=> state_q == ompc_pkg::OMPC_START)
      else $error("interrupt did not wake");
   a_pa_wakes: assert property (
      pa_wake |=> state_q == ompc_pkg::OMPC_START)
      else $error("port A change did not wake");
   a_idle_dead: assert property (
      is_idle && !(|(irq_req & ~irq_pre_q & ~ompc_pkg::IRQ_NEEDS_32K))
      && !pa_wake && !any_reset |=> is_idle)
      else $error("crystal-fed interrupt woke idle");
   a_startup_len: assert property (
      $rose(state_q == ompc_pkg::OMPC_START) |-> !cpu_run [*8]
      ##0 (state_q == ompc_pkg::OMPC_START))
      else $error("start-up delay too short");
   a_startup_hold: assert property (
      state_q == ompc_pkg::OMPC_START && !sst_done |=> !cpu_run)
      else $error("cpu ran inside start-up delay");
   a_startup_end: assert property (
      sst_done |=> cpu_run && state_q == ompc_pkg::OMPC_GREEN)
      else $error("no resume after start-up");
   a_irq_late: assert property (
      sst_done && wake_irq_q |=> !irq_take ##1 irq_take)
      else $error("interrupt entry not delayed");
   a_no_irq: assert property (
      sst_done && !wake_irq_q |=> !irq_take ##1 !irq_take)
      else $error("interrupt taken without acknowledge");
   a_pre_flag: assert property (
      in_halt && (irq_live == irq_pre_q) && !pa_wake && !any_reset
      |=> in_halt)
      else $error("stale flag woke device");
   a_wdt_instr: assert property (
      in_halt && $past(wdt_src_sel) == ompc_pkg::WDT_SRC_INSTR
      |-> !watchdog_run)
      else $error("watchdog ran on instruction clock in halt");
   a_wdt_idle_32k: assert property (
      is_idle && $past(wdt_src_sel) == ompc_pkg::WDT_SRC_32K
      |-> !watchdog_run)
      else $error("watchdog ran on crystal in idle");
   a_wdt_own: assert property (
      in_halt && $past(wdt_src_sel) == ompc_pkg::WDT_SRC_OWN
      && $past(wdt_enable) |-> watchdog_run)
      else $error("own-oscillator watchdog stopped in halt");
   a_wdt_restart: assert property (
      halt_go && wd_run_d |=> watchdog_clear)
      else $error("watchdog not cleared at halt");
   a_wdt_flag: assert property (
      in_halt && wdt_timeout_evt
      |=> timeout_flag && power_down_flag)
      else $error("watchdog wake flags wrong");
   a_ext_flag: assert property (
      in_halt && ext_reset_evt && !wdt_timeout_evt
      |=> !timeout_flag && power_down_flag)
      else $error("external wake flags wrong");
   a_normal_sel: assert property (
      state_q == ompc_pkg::OMPC_GREEN && !halt_go && mode_select_high
      && upconvert_enable |=> fast_clk_sel && osc_fast_en)
      else $error("normal mode not entered");
   a_green_sel: assert property (
      state_q == ompc_pkg::OMPC_NORMAL && !mode_select_high
      && !upconvert_enable |=> !fast_clk_sel && !osc_fast_en)
      else $error("green mode kept fast clock");

   c_sleep: cover property (
      state_q == ompc_pkg::OMPC_SLEEP ##1 state_q == ompc_pkg::OMPC_START);
   c_idle: cover property (
      state_q == ompc_pkg::OMPC_IDLE ##1 state_q == ompc_pkg::OMPC_START);
   c_irq: cover property (irq_take);
   c_normal: cover property (state_q == ompc_pkg::OMPC_NORMAL);
   c_pa_wake: cover property (pa_wake);
endmodule : ompc_ctrl

// File: verif/tb_operating_mode_power_control.sv
// self-checking bench for the operating-mode and halt/wake controller
`timescale 1ns/1ps
module tb_operating_mode_power_control;
   logic       ref_clk, rst_b, halt_exec, mode_select_high, mode_select_low;
   logic       upconvert_enable, ext_reset_evt, wdt_timeout_evt, stack_full;
   logic [7:0] irq_req, irq_enable, port_a_pins;
   logic [1:0] wdt_src_sel;
   logic       wdt_enable, sys_clk_en, osc_32k_en, osc_fast_en, fast_clk_sel;
   logic       cpu_run, irq_take, watchdog_run, watchdog_clear;
   logic       power_down_flag, timeout_flag, clr_seen;
   int         n_mismatch, cmp_count, exp_pdf, exp_to, bit_i;
   // ==========================================
   // clock, design
   initial begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end
   ompc_ctrl i_ompc_ctrl (.ref_clk(ref_clk), .rst_b(rst_b),
      .halt_exec(halt_exec), .mode_select_high(mode_select_high),
      .mode_select_low(mode_select_low), .upconvert_enable(upconvert_enable),
      .ext_reset_evt(ext_reset_evt), .wdt_timeout_evt(wdt_timeout_evt),
      .irq_req(irq_req), .irq_enable(irq_enable), .stack_full(stack_full),
      .port_a_pins(port_a_pins), .wdt_src_sel(wdt_src_sel),
      .wdt_enable(wdt_enable), .sys_clk_en(sys_clk_en),
      .osc_32k_en(osc_32k_en), .osc_fast_en(osc_fast_en),
      .fast_clk_sel(fast_clk_sel), .cpu_run(cpu_run), .irq_take(irq_take),
      .watchdog_run(watchdog_run), .watchdog_clear(watchdog_clear),
      .power_down_flag(power_down_flag), .timeout_flag(timeout_flag));
   // ==========================================
   // checking helpers
   task automatic chk(string name, logic [7:0] seen, logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk
   task automatic finish_test();
      $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : finish_test
   task automatic cyc(int n);
      repeat (n) @(negedge ref_clk);
   endtask : cyc
   // issue the stop instruction from green; a sleep/idle entry is expected
   task automatic do_halt(logic low, logic [1:0] src);
      logic wd_exp;
      mode_select_low = low;
      wdt_src_sel     = src;
      halt_exec       = 1'b1;
      clr_seen        = 1'b0;
      cyc(1);
      halt_exec = 1'b0;
      exp_pdf   = 1;
      exp_to    = 0;
      for (int k = 0; k < 3; k++) begin
         clr_seen |= watchdog_clear;
         cyc(1);
      end
      chk("sys_clk_en", sys_clk_en, 8'h00);
      chk("osc_32k_en", osc_32k_en, {7'h0, ~low});
      chk("osc_fast_en", osc_fast_en, 8'h00);
      chk("pdf", power_down_flag, exp_pdf[7:0]);
      chk("to", timeout_flag, exp_to[7:0]);
      // own oscillator always runs; the crystal only while it stays on
      wd_exp = wdt_enable && (src == ompc_pkg::WDT_SRC_OWN ||
               (src == ompc_pkg::WDT_SRC_32K && !low));
      chk("wdt_run", watchdog_run, {7'h0, wd_exp});
      chk("wdt_clear", clr_seen, {7'h0, wd_exp});
      chk("cpu_run", cpu_run, 8'h00);
   endtask : do_halt
   // wait for resume, then look for the interrupt entry
   task automatic wake_wait(logic exp_irq);
      int  cnt;
      logic got;
      logic ok;
      cnt = 0;
      got = 1'b0;
      while (!cpu_run && cnt < 1100) begin
         cyc(1);
         cnt++;
      end
      ok = cnt >= ompc_pkg::STARTUP_CYCLES &&
           cnt <= ompc_pkg::STARTUP_CYCLES + 1;
      chk("startup_ok", {7'h0, ok}, 8'h01);
      chk("irq_now", irq_take, 8'h00);
      for (int k = 0; k < 4; k++) begin
         cyc(1);
         got |= irq_take;
      end
      chk("irq_take", got, {7'h0, exp_irq});
      chk("sys_clk_green", sys_clk_en, 8'h01);
      chk("fast_sel", fast_clk_sel, 8'h00);
      chk("pdf_w", power_down_flag, exp_pdf[7:0]);
      chk("to_w", timeout_flag, exp_to[7:0]);
   endtask : wake_wait
   // ==========================================
   // watchdog on hangs
   initial begin
      #200us;
      n_mismatch++;
      finish_test();
   end
   // ==========================================
   // main sequence
   initial begin
      rst_b = 1'b0; halt_exec = 1'b0; mode_select_high = 1'b0;
      mode_select_low = 1'b0; upconvert_enable = 1'b0; ext_reset_evt = 1'b0;
      wdt_timeout_evt = 1'b0; stack_full = 1'b0; irq_req = 8'h00;
      irq_enable = 8'h00; wdt_src_sel = 2'h0; wdt_enable = 1'b1;
      n_mismatch = 0; cmp_count = 0;
      port_a_pins = 8'h00;
      void'($urandom(32'ha096));
      cyc(16);
      chk("pdf_por", power_down_flag, 8'h00);
      chk("to_por", timeout_flag, 8'h00);
      rst_b = 1'b1;
      exp_pdf = 0;
      exp_to = 0;
      wake_wait(1'b0);
      // sleep, fresh enabled interrupt, stack free
      bit_i = 4 + ($urandom % 4);
      irq_enable = 8'hff;
      do_halt(1'b0, ompc_pkg::WDT_SRC_INSTR);
      irq_req[bit_i] = 1'b1;
      wake_wait(1'b1);
      irq_req = 8'h00;
      // idle: crystal-fed interrupt is dead, stack full then blocks entry
      stack_full = 1'b1;
      do_halt(1'b1, ompc_pkg::WDT_SRC_32K);
      irq_req[$urandom % 4] = 1'b1;
      cyc(30);
      chk("idle_dead", cpu_run, 8'h00);
      irq_req[bit_i] = 1'b1;
      wake_wait(1'b0);
      // flag already set at entry never wakes; port A change resumes with interrupts disabled
      stack_full = 1'b0;
      irq_enable = 8'h00;
      // random port level settles through the synchroniser before halt
      port_a_pins = 8'($urandom);
      cyc(6);
      do_halt(1'b0, ompc_pkg::WDT_SRC_OWN);
      cyc(30);
      chk("preset_flag", cpu_run, 8'h00);
      irq_req = 8'h00;
      cyc(40);
      chk("pa_still", cpu_run, 8'h00);
      bit_i = $urandom % 8;
      port_a_pins[bit_i] = ~port_a_pins[bit_i];
      // three synchroniser stages plus the agree stage before the wake
      cyc(4);
      wake_wait(1'b0);
      // watchdog timeout and external reset during halt
      do_halt(1'b0, ompc_pkg::WDT_SRC_OWN);
      wdt_timeout_evt = 1'b1;
      cyc(1);
      wdt_timeout_evt = 1'b0;
      exp_to = 1;
      wake_wait(1'b0);
      do_halt(1'b1, ompc_pkg::WDT_SRC_INSTR);
      ext_reset_evt = 1'b1;
      cyc(1);
      ext_reset_evt = 1'b0;
      wake_wait(1'b0);
      // green to normal, halt refused there, and back
      chk("green_fast", osc_fast_en, 8'h00);
      upconvert_enable = 1'b1;
      cyc(20);
      mode_select_high = 1'b1;
      cyc(3);
      chk("normal_sel", fast_clk_sel, 8'h01);
      chk("normal_osc", osc_fast_en, 8'h01);
      halt_exec = 1'b1;
      cyc(1);
      halt_exec = 1'b0;
      cyc(3);
      chk("no_halt", sys_clk_en, 8'h01);
      chk("no_halt_to", timeout_flag, 8'h00);
      mode_select_high = 1'b0;
      upconvert_enable = 1'b0;
      cyc(4);
      chk("back_green", fast_clk_sel, 8'h00);
      finish_test();
   end
endmodule : tb_operating_mode_power_control
